// File: lps_regs.vh
`ifndef LPS_REGS_VH
`define LPS_REGS_VH
// Register map
`define LPS_PWR_SAVE_OFS   8'h08
`define LPS_PWR_SAVE_RST   8'h00
`define LPS_PS_EN_BIT      0
// Command codes on the indirect port
`define LPS_CMD_SYSTEM_SET 8'h40
`define LPS_CMD_POWER_SAVE 8'h53
// Frame timing: default frame length in core clocks
`define LPS_FRAME_CYCLES   16'h1000
`define LPS_LINE_CYCLES    16'h0020
`endif

// File: lps_frame_timer.v
`timescale 1ns/1ps
`include "lps_regs.vh"
// Frame and line tick generator; halts while the clock gate is closed
module lps_frame_timer #(
  parameter [15:0] FRAME_CYCLES = `LPS_FRAME_CYCLES,
  parameter [15:0] LINE_CYCLES  = `LPS_LINE_CYCLES
) (
  input  wire        core_clk,   // Core clock
  input  wire        sys_rst,    // Async reset
  input  wire        clk_en,     // Clock enable
  input  wire        run,        // Internal clock gate open
  output reg         frame_tick, // Last cycle of a frame
  output reg         line_tick,  // Last cycle of a line
  output reg         phase       // Half-rate toggle for panel clocks
);
  reg [15:0] frame_cnt_r;
  reg [15:0] line_cnt_r;

  // Counters stop dead when run is low, so nothing toggles in power save
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_cnt_r <= 16'h0000;
      line_cnt_r  <= 16'h0000;
      frame_tick  <= 1'b0;
      line_tick   <= 1'b0;
      phase       <= 1'b0;
    end else if (clk_en) begin
      frame_tick <= 1'b0;
      line_tick  <= 1'b0;
      if (run) begin
        phase <= ~phase;
        if (frame_cnt_r == FRAME_CYCLES - 16'h0001) begin
          frame_cnt_r <= 16'h0000;
          frame_tick  <= 1'b1;
        end else begin
          frame_cnt_r <= frame_cnt_r + 16'h0001;
        end
        if (line_cnt_r == LINE_CYCLES - 16'h0001) begin
          line_cnt_r <= 16'h0000;
          line_tick  <= 1'b1;
        end else begin
          line_cnt_r <= line_cnt_r + 16'h0001;
        end
      end
    end
  end
endmodule

// File: lps_power_ctrl.v
`timescale 1ns/1ps
`include "lps_regs.vh"
// Overview of operation
// - Enter power save only after one full blank frame has been output.
// - In power save send blank column data and drive row driver disable.
// - Registers keep contents; memory control outputs hold their levels.
// - Writing zero to the enable bit leaves power save.
// - Indirect power save command is complete without parameter bytes.
// - Indirect system setup command leaves power save.
// - Row driver disable goes low one to two frames after the request.
// - All internal clocks, oscillator output included, stop in power save.
// - Host data bus and wait output go high impedance in power save.
// - Display off or power save holds panel outputs low, row clock high.
// - Pixel shift clock held low in power save only.
module lps_power_ctrl #(
  parameter [15:0] FRAME_CYCLES = `LPS_FRAME_CYCLES,
  parameter [15:0] LINE_CYCLES  = `LPS_LINE_CYCLES
) (
  input  wire       core_clk,            // 25 MHz core clock
  input  wire       sys_rst,             // Async reset, active high
  input  wire       clk_en,              // Freezes all state when low
  input  wire       indirect_mode,       // Pin strap: indirect addressing
  input  wire       host_wr,             // Host write strobe (async pin)
  input  wire       host_rd,             // Host read strobe (async pin)
  input  wire       host_cmd,            // Indirect: byte is a command
  input  wire [7:0] host_addr,           // Direct register address
  input  wire [7:0] host_din,            // Host write data
  input  wire       disp_on,             // Display enabled by display logic
  input  wire [3:0] pix_data,            // Pixel data from display logic
  input  wire       mem_ctrl_in,         // Memory control level from core
  output reg  [7:0] host_dout,           // Host read data
  output reg        host_dout_oe,        // Data bus drive enable
  output reg        host_wait_n,         // Host wait, active low
  output reg        host_wait_oe,        // Wait drive enable
  output reg        row_driver_disable,  // Low disables row drivers
  output reg        frame_pulse,         // Panel frame pulse
  output reg        line_pulse,          // Panel line pulse
  output reg        row_shift_clock,     // Row shift clock
  output reg        ac_modulation,       // AC modulation
  output reg        column_enable_chain, // Column enable chain
  output reg        pixel_shift_clock,   // Pixel shift clock
  output reg  [3:0] panel_data,          // Panel data
  output reg        oscillator_output,   // Oscillator output
  output reg        mem_ctrl,            // Held memory control level
  output reg        ps_active            // Power save state
);
  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_BLANK = 4'b0010;
  localparam [3:0] ST_DRAIN = 4'b0100;
  localparam [3:0] ST_SAVE  = 4'b1000;
  // Full reset byte of the control register; only the enable bit is kept
  localparam [7:0] PS_RST   = `LPS_PWR_SAVE_RST;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg       ps_en_r;
  reg [1:0] wr_sync_r;
  reg [1:0] rd_sync_r;
  reg       wr_prev_r;
  reg       rd_prev_r;
  reg [17:0] bus_sync0_r;
  reg [17:0] bus_sync1_r;
  wire       sync_ind;
  wire       sync_cmd;
  wire [7:0] sync_addr;
  wire [7:0] sync_din;
  reg       run_clk;
  wire      frame_tick;
  wire      line_tick;
  wire      phase;
  wire      wr_pulse;
  wire      rd_pulse;
  wire      reg_hit;
  wire      ps_cmd;
  wire      sys_cmd;
  wire      blank;

  // Host pins cross in via two flops; bus pins keep step with the strobes
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_sync_r   <= 2'b00;
      rd_sync_r   <= 2'b00;
      wr_prev_r   <= 1'b0;
      rd_prev_r   <= 1'b0;
      bus_sync0_r <= 18'h00000;
      bus_sync1_r <= 18'h00000;
    end else if (clk_en) begin
      wr_sync_r   <= {wr_sync_r[0], host_wr};
      rd_sync_r   <= {rd_sync_r[0], host_rd};
      bus_sync0_r <= {indirect_mode, host_cmd, host_addr, host_din};
      bus_sync1_r <= bus_sync0_r;
      wr_prev_r <= wr_sync_r[1];
      rd_prev_r <= rd_sync_r[1];
    end
  end

  assign wr_pulse = wr_sync_r[1] & ~wr_prev_r;
  assign rd_pulse = rd_sync_r[1] & ~rd_prev_r;
  assign sync_ind  = bus_sync1_r[17];
  assign sync_cmd  = bus_sync1_r[16];
  assign sync_addr = bus_sync1_r[15:8];
  assign sync_din  = bus_sync1_r[7:0];
  assign reg_hit  = ~sync_ind & (sync_addr == `LPS_PWR_SAVE_OFS);
  assign ps_cmd   = sync_ind & sync_cmd & (sync_din == `LPS_CMD_POWER_SAVE);
  assign sys_cmd  = sync_ind & sync_cmd & (sync_din == `LPS_CMD_SYSTEM_SET);
  // Blank whenever display off or not in normal running
  assign blank    = ~disp_on | (state_r != ST_RUN);

  // enable bit reads back; exit by zero write
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ps_en_r <= PS_RST[`LPS_PS_EN_BIT];
    end else if (clk_en && wr_pulse) begin
      if (reg_hit) begin
        ps_en_r <= sync_din[`LPS_PS_EN_BIT];
      end else if (ps_cmd) begin
        ps_en_r <= 1'b1;
      end else if (sys_cmd) begin
        ps_en_r <= 1'b0;
      end
    end
  end

  // Sequencer: blank to the end of the current frame, then drain one whole frame, then save
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (ps_en_r) state_nxt = ST_BLANK;
      end
      ST_BLANK: begin
        if (!ps_en_r) state_nxt = ST_RUN;
        else if (frame_tick) state_nxt = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (!ps_en_r) state_nxt = ST_RUN;
        else if (frame_tick) state_nxt = ST_SAVE;
      end
      ST_SAVE: begin
        if (!ps_en_r) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_RUN;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // clocks gated off once in save state
  always @* begin
    run_clk = (state_r != ST_SAVE);
  end

  lps_frame_timer #(
    .FRAME_CYCLES (FRAME_CYCLES),
    .LINE_CYCLES  (LINE_CYCLES)
  ) u_timer (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .run        (run_clk),
    .frame_tick (frame_tick),
    .line_tick  (line_tick),
    .phase      (phase)
  );

  // Panel pins; display logic is gated by blank so no stray image shows
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_driver_disable  <= 1'b0;
      frame_pulse         <= 1'b0;
      line_pulse          <= 1'b0;
      row_shift_clock     <= 1'b1;
      ac_modulation       <= 1'b0;
      column_enable_chain <= 1'b0;
      pixel_shift_clock   <= 1'b0;
      panel_data          <= 4'h0;
      oscillator_output   <= 1'b0;
      ps_active           <= 1'b0;
    end else if (clk_en) begin
      ps_active <= (state_r == ST_SAVE);
      oscillator_output <= run_clk ? ~oscillator_output : 1'b0;
      panel_data <= blank ? 4'h0 : pix_data;
      // drop on save entry
      // Drivers stay enabled over the blank frames, so the drop lands one to two frames late
      row_driver_disable  <= disp_on & (state_r != ST_SAVE);
      // idle levels in off or save
      frame_pulse         <= blank ? 1'b0 : frame_tick;
      line_pulse          <= blank ? 1'b0 : line_tick;
      row_shift_clock     <= blank ? 1'b1 : ~line_tick;
      column_enable_chain <= blank ? 1'b0 : line_tick;
      if (blank) begin
        ac_modulation <= 1'b0;
      end else if (frame_tick) begin
        ac_modulation <= ~ac_modulation;
      end
      // low in save, free when off
      pixel_shift_clock <= (state_r == ST_SAVE) ? 1'b0 : phase;
    end
  end

  // memory control level frozen while saving
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ctrl <= 1'b0;
    end else if (clk_en && state_r != ST_SAVE) begin
      mem_ctrl <= mem_ctrl_in;
    end
  end

  // Host bus answer; bus and wait released in save
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_dout    <= 8'h00;
      host_dout_oe <= 1'b0;
      host_wait_n  <= 1'b1;
      host_wait_oe <= 1'b0;
    end else if (clk_en) begin
      host_wait_n  <= 1'b1;
      // Released in step with ps_active so the bus never drives while saving
      host_wait_oe <= (state_r != ST_SAVE);
      if (state_r == ST_SAVE) begin
        host_dout_oe <= 1'b0;
      end else begin
        host_dout_oe <= rd_sync_r[1];
      end
      if (rd_pulse) begin
        host_dout <= reg_hit ? {7'h00, ps_en_r} : 8'h00;
      end
    end
  end
endmodule

// File: lps_host_model.sv
`timescale 1ns/1ps
// Host side: each request is one strobe held 4 cycles, then 4 cycles low
module lps_host_model (
  input  wire       core_clk,  // Core clock
  input  wire       go,        // Start request
  input  wire       rd,        // 1 read, 0 write
  input  wire       cmd,       // Byte is a command
  input  wire [7:0] addr,      // Address
  input  wire [7:0] data,      // Write data
  output reg        host_wr,   // Write strobe
  output reg        host_rd,   // Read strobe
  output reg        host_cmd,  // Command flag
  output reg  [7:0] host_addr, // Address pins
  output reg  [7:0] host_din,  // Data pins
  output reg        busy       // Request in progress
);
  reg [3:0] cnt_r;
  initial {host_wr, host_rd, host_cmd, host_addr, host_din, busy, cnt_r} = 24'h000000;
  // command alone
  // A released data bus shows the inverse, so a stale byte cannot pass
  always @(posedge core_clk) begin
    if (go && !busy) begin
      {busy, cnt_r, host_wr, host_rd} <= {1'b1, 4'h0, !rd, rd};
      {host_cmd, host_addr, host_din} <= {cmd, addr, data};
    end else if (busy) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'h3)
        {host_wr, host_rd} <= 2'b00;
      if (cnt_r == 4'h4)
        host_din <= ~host_din;
      if (cnt_r == 4'h7)
        busy <= 1'b0;
    end
  end
endmodule

// File: lps_power_ctrl_chk.sv
`timescale 1ns/1ps
// Port checks of power save entry, exit and pin states
module lps_power_ctrl_chk #(
  parameter [15:0] FRAME_CYCLES = 16'h0010
) (
  input wire       core_clk,           // Clock
  input wire       sys_rst,            // Reset
  input wire       clk_en,             // Enable
  input wire       indirect_mode,      // Strap
  input wire       host_wr,            // Write strobe
  input wire       host_cmd,           // Command flag
  input wire [7:0] host_addr,          // Address
  input wire [7:0] host_din,           // Write data
  input wire       host_dout_oe,       // Bus enable
  input wire       host_wait_oe,       // Wait enable
  input wire       row_driver_disable, // Row drivers
  input wire       line_pulse,         // Line pulse
  input wire       pixel_shift_clock,  // Pixel clock
  input wire [3:0] panel_data,         // Panel data
  input wire       oscillator_output,  // Oscillator
  input wire       mem_ctrl,           // Memory control
  input wire       ps_active           // Save state
);
  localparam int RDD_MAX = 2 * FRAME_CYCLES + 6;
  localparam int ENT_MAX = 3 * FRAME_CYCLES + 8;
  reg [15:0] blank_cnt_r;
  wire       dir08 = !indirect_mode && host_addr == 8'h08;
  wire       ind_c = indirect_mode && host_cmd;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Enabled cycles since the last line pulse; saturates so long blanks never wrap
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      blank_cnt_r <= 16'h0000;
    else if (line_pulse)
      blank_cnt_r <= 16'h0000;
    else if (clk_en && blank_cnt_r != 16'hFFFF)
      blank_cnt_r <= blank_cnt_r + 16'h0001;
  end
  AST_ENTRY_BLANK: assert property ($rose(ps_active) |-> blank_cnt_r >= FRAME_CYCLES)
    else $error("power save entered before a full blank frame");
  AST_SAVE_BLANK: assert property (ps_active |-> !row_driver_disable && panel_data == 4'h0)
    else $error("panel not blanked in power save");
  AST_MEM_HOLD: assert property (ps_active && $past(ps_active) |-> $stable(mem_ctrl))
    else $error("memory control moved in power save");
  AST_EXIT_WR: assert property ($rose(host_wr) && dir08 && !host_din[0] |-> ##[1:6] !ps_active)
    else $error("no exit after enable cleared");
  AST_CMD_SAVE: assert property ($rose(host_wr) && ind_c && host_din == 8'h53
    |-> ##[1:ENT_MAX] ps_active) else $error("save command alone did not enter");
  AST_CMD_SETUP: assert property ($rose(host_wr) && ind_c && host_din == 8'h40
    |-> ##[1:6] !ps_active) else $error("setup command did not exit");
  AST_RDD_LOW: assert property ($rose(host_wr) && dir08 && host_din[0]
    |-> ##[1:RDD_MAX] !row_driver_disable) else $error("row drivers not disabled in time");
  AST_OSC_STOP: assert property (ps_active && $past(ps_active) |-> $stable(oscillator_output))
    else $error("oscillator running in power save");
  AST_BUS_HIZ: assert property (ps_active |-> !host_dout_oe && !host_wait_oe)
    else $error("host bus driven in power save");
  AST_PIX_LOW: assert property (ps_active |-> !pixel_shift_clock)
    else $error("pixel clock high in power save");
endmodule
bind lps_power_ctrl lps_power_ctrl_chk #(.FRAME_CYCLES(FRAME_CYCLES)) i_lps_power_ctrl_chk (.*);

// File: lps_power_ctrl_test.sv
`timescale 1ns/1ps
module lps_power_ctrl_test;
  reg          core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, indirect_mode = 1'b0;
  reg          disp_on = 1'b1, mem_ctrl_in = 1'b0, go = 1'b0, rd = 1'b0, cmd = 1'b0;
  reg  [3:0]   pix_data = 4'h0;
  reg  [7:0]   addr = 8'h00, data = 8'h00;
  wire         host_wr, host_rd, host_cmd, busy, host_dout_oe, host_wait_n, host_wait_oe;
  wire         row_driver_disable, frame_pulse, line_pulse, row_shift_clock, ac_modulation;
  wire         column_enable_chain, pixel_shift_clock, oscillator_output, mem_ctrl, ps_active;
  wire [7:0]   host_addr, host_din, host_dout;
  wire [3:0]   panel_data;
  integer      seed = 21083, num_errors = 0, n_tests = 0, cycles = 0;
  reg          oe_q = 1'b0;
  logic [15:0] exp_q[$];
  wire  [15:0] pins = {host_wait_oe, host_wait_n, 3'b000, ps_active, row_driver_disable,
                       frame_pulse, line_pulse, ac_modulation, column_enable_chain,
                       panel_data, row_shift_clock};
  always #20 core_clk = ~core_clk;
  lps_power_ctrl #(.FRAME_CYCLES(16'h0010), .LINE_CYCLES(16'h0004)) i_lps_power_ctrl (.*);
  lps_host_model i_lps_host_model (.*);
  task check(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One host request; a read outside power save leaves its expected byte
  task xfer(input logic r, input logic c, input logic [7:0] a, input logic [7:0] d);
    integer k;
    if (r && ps_active !== 1'b1)
      exp_q.push_back({8'h00, d});
    {go, rd, cmd, addr, data} <= {1'b1, r, c, a, d};
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    for (k = 0; k < 20 && busy === 1'b1; k = k + 1) @(posedge core_clk);
  endtask
  task wait_ps(input logic v);
    integer k;
    for (k = 0; k < 90 && ps_active !== v; k = k + 1) @(posedge core_clk);
  endtask
  // Read data is judged when the bus is let go; any answer in save is stray
  always @(posedge core_clk) begin
    oe_q <= host_dout_oe;
    if (oe_q === 1'b1 && host_dout_oe === 1'b0) begin
      if (exp_q.size() == 0)
        check(16'hFFFF, 16'h0000, "stray read answer");
      else
        check({8'h00, host_dout}, exp_q.pop_front(), "read data");
    end
  end
  // Random pixel and memory levels, and the hang limit
  always @(posedge core_clk) begin
    {mem_ctrl_in, pix_data} <= 5'($random(seed));
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    xfer(1, 0, 8'h08, 8'h00);
    xfer(1, 0, {5'h00, 3'($random(seed))}, 8'h00);
    xfer(0, 0, 8'h08, 8'h01);
    xfer(1, 0, 8'h08, 8'h01);
    wait_ps(1);
    check(pins, 16'h4401, "save entry pins");
    xfer(1, 0, 8'h08, 8'h01);
    xfer(0, 0, 8'h08, 8'h00);
    wait_ps(0);
    check(ps_active, 16'h0000, "direct exit");
    xfer(0, 0, {5'h00, 3'($random(seed))}, 8'($random(seed)));
    xfer(1, 0, 8'h08, 8'h00);
    disp_on <= 1'b0;
    repeat (3) @(posedge core_clk);
    repeat (8) begin
      @(posedge core_clk);
      check(pins, 16'hC001, "display off pins");
    end
    {disp_on, clk_en} <= 2'b10;
    repeat (5) @(posedge core_clk);
    {clk_en, indirect_mode} <= 2'b11;
    @(posedge core_clk);
    xfer(0, 1, 8'h00, 8'h53);
    wait_ps(1);
    check(ps_active, 16'h0001, "command entry");
    xfer(0, 1, 8'h00, 8'h40);
    wait_ps(0);
    check(ps_active, 16'h0000, "setup exit");
    repeat (2) xfer(0, 0, 8'h00, 8'($random(seed)));
    check(16'(exp_q.size()), 16'h0000, "unanswered reads");
    final_report;
  end
endmodule
